// file: rsbs_pin_if.sv
// rsbs_pin_if: one raw pin-domain level and its synchronised views.
// assumes the sync end drives level, rise and held_low on sys_clk.
`timescale 1ns/100ps
interface rsbs_pin_if;
	logic raw;
	logic level;
	logic rise;
	logic held_low;
	modport sync (input raw, output level, rise, held_low);
	modport user (output raw, input level, rise, held_low);
endinterface : rsbs_pin_if

// file: rsbs_pin_sync.sv
// rsbs_pin_sync: two-flop synchroniser, rising-edge detect and low-time filter.
// assumes raw is asynchronous to sys_clk and idles high.
`timescale 1ns/100ps
module rsbs_pin_sync #(
	parameter int FILTER_CYCLES = 24
) (
	input wire logic sys_clk,
	input wire logic srst,
	rsbs_pin_if.sync pin
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic [7:0] cnt;
		logic held_low;
	} rsbs_sync_st_t;

	rsbs_sync_st_t st_reg;
	rsbs_sync_st_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = pin.raw;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2) begin
			st_next.cnt = 8'h00;
		end else if (st_reg.cnt != 8'(FILTER_CYCLES)) begin
			st_next.cnt = st_reg.cnt + 8'h01;
		end
		// short glitches never reach the count, so they never reset the chip
		st_next.held_low = !st_reg.s2 && (st_next.cnt == 8'(FILTER_CYCLES));
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: 8'h00, held_low: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign pin.level = st_reg.s2;
	assign pin.rise = st_reg.s2 && !st_reg.s3;
	assign pin.held_low = st_reg.held_low;
endmodule : rsbs_pin_sync

// file: rsbs_pkg.sv
// rsbs_pkg: register map, field positions, reset values and counts for the
// reset-source and boot-select block.
// assumes an 8-bit special-function-register bus and one 20 MHz system clock.
package rsbs_pkg;
	// register addresses
	localparam logic [7:0] ADDR_POWER_CTL = 8'h87;
	localparam logic [7:0] ADDR_CHIP_CONTROL = 8'h9f;
	localparam logic [7:0] ADDR_AUX_CONTROL = 8'ha2;
	localparam logic [7:0] ADDR_WDOG_CONTROL = 8'haa;
	localparam logic [7:0] ADDR_ACCESS_KEY = 8'hc7;

	// field positions
	localparam int CHP_TRIG_BIT = 7;
	localparam int CHP_PROG_FAIL_BIT = 6;
	localparam int CHP_BOOT_BIT = 1;
	localparam int CHP_PROG_EN_BIT = 0;
	localparam int AUX_SOFT_FLAG_BIT = 7;
	localparam int AUX_PIN_FLAG_BIT = 6;
	localparam int AUX_FAULT_FLAG_BIT = 5;
	localparam int AUX_SPARE_BIT = 3;
	localparam int AUX_SERIAL_SWAP_BIT = 2;
	localparam int AUX_PTR_SEL_BIT = 0;
	localparam int WD_RUN_BIT = 7;
	localparam int WD_CLEAR_BIT = 6;
	localparam int WD_EXPIRED_BIT = 5;
	localparam int WD_IDLE_RUN_BIT = 4;
	localparam int WD_FLAG_BIT = 3;
	localparam int PWR_ON_FLAG_BIT = 4;
	localparam int CFG_BOOT_BIT = 7;

	// key bytes and values after reset
	localparam logic [7:0] KEY_FIRST = 8'haa;
	localparam logic [7:0] KEY_SECOND = 8'h55;
	localparam logic [7:0] CFG_RESET = 8'hff;
	localparam logic [15:0] BOOT_VECTOR = 16'h0000;
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] PORT_LATCH_RESET = 8'hff;
	localparam logic [7:0] CLKDIV_UNDIVIDED = 8'h00;
	localparam logic [2:0] WD_PRESCALE_RESET = 3'h0;

	// counts of cycles
	localparam logic [2:0] KEY_WINDOW_CYCLES = 3'h4;
	localparam logic [3:0] RST_HOLD_CYCLES = 4'h2;
	localparam int EXT_FILTER_CYCLES = 24;
	localparam logic [9:0] DBG_QUASI_LSO_CLKS = 10'h258;

	typedef enum logic {RSBS_RUN, RSBS_HOLD} rsbs_state_t;
	typedef enum logic [1:0] {RSBS_KEY_IDLE, RSBS_KEY_ARMED, RSBS_KEY_OPEN} rsbs_key_t;
endpackage : rsbs_pkg

// file: rsbs_reset_boot.sv
// rsbs_reset_boot: reset sequencer, reset-source flags, timed-access unlock
// and boot-block select, reached over the special-function-register bus.
// assumes sfr strobes are one-cycle pulses on sys_clk; srst is the cold
// (power-on) reset; watchdog, brown-out and fault events are sys_clk pulses.
`timescale 1ns/100ps
module rsbs_reset_boot
	import rsbs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic ext_rst_n,
	input wire logic low_speed_osc,
	input wire logic wdt_timeout,
	input wire logic bod_reset_event,
	input wire logic hardfault_event,
	input wire logic power_down,
	input wire logic [7:0] clock_divider_value,
	input wire logic cfg_load,
	input wire logic [7:0] cfg_data,
	output logic core_rst,
	output logic cpu_stall,
	output logic boot_loader_sel,
	output logic [15:0] fetch_addr,
	output logic [7:0] stack_init,
	output logic [7:0] port_latch_init,
	output logic port_input_only,
	output logic periph_irq_disable,
	output logic ram_retained,
	output logic debug_pin_quasi,
	output logic wdt_clear,
	output logic wdt_run,
	output logic [2:0] wdt_prescale,
	output logic wdt_reset_lost
);
	typedef struct packed {
		rsbs_state_t st;
		logic [3:0] hold_cnt;
		logic soft_trig;
		logic boot_sel;
		logic prog_fail;
		logic prog_en;
		logic soft_flag;
		logic pin_flag;
		logic fault_flag;
		logic spare;
		logic serial_swap;
		logic ptr_sel;
		logic pwr_on_flag;
		logic wd_run;
		logic wd_expired;
		logic wd_idle_run;
		logic wd_flag;
		logic [2:0] wd_ps;
		rsbs_key_t key_st;
		logic [2:0] key_cnt;
		logic [7:0] cfg;
		logic [7:0] rdata;
		logic core_rst;
		logic wd_clear;
		logic wd_lost;
		logic cold;
		logic dbg_quasi;
		logic [9:0] lso_cnt;
	} rsbs_st_t;

	rsbs_st_t st_reg;
	rsbs_st_t st_next;

	rsbs_pin_if ext_if ();
	rsbs_pin_if lso_if ();

	logic wr;
	logic key_open;
	logic prot_hit;
	logic soft_go;
	logic wdt_go;
	logic pin_go;
	logic any_go;
	logic reload_boot;

	assign ext_if.raw = ext_rst_n;
	assign lso_if.raw = low_speed_osc;

	rsbs_pin_sync #(
		.FILTER_CYCLES(EXT_FILTER_CYCLES)
	) u_ext_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.pin(ext_if.sync)
	);

	// the slow oscillator is only counted by edges, so no filter is needed
	rsbs_pin_sync #(
		.FILTER_CYCLES(1)
	) u_lso_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.pin(lso_if.sync)
	);

	always_comb begin
		st_next = st_reg;
		st_next.wd_clear = 1'b0;
		st_next.wd_lost = 1'b0;

		// register writes are ignored while the core is held in reset
		wr = sfr_wr && (st_reg.st == RSBS_RUN);
		key_open = (st_reg.key_st == RSBS_KEY_OPEN);
		prot_hit = wr && key_open && (sfr_addr == ADDR_CHIP_CONTROL || sfr_addr == ADDR_WDOG_CONTROL);

		unique case (st_reg.key_st)
			RSBS_KEY_IDLE: begin
				st_next.key_st = RSBS_KEY_IDLE;
			end
			RSBS_KEY_ARMED: begin
				if (wr && sfr_addr != ADDR_ACCESS_KEY) begin
					st_next.key_st = RSBS_KEY_IDLE;
				end
			end
			RSBS_KEY_OPEN: begin
				// window closes on time-out or after one protected write
				if (st_reg.key_cnt == 3'h0 || prot_hit) begin
					st_next.key_st = RSBS_KEY_IDLE;
				end else begin
					st_next.key_cnt = st_reg.key_cnt - 3'h1;
				end
			end
		endcase
		if (wr && sfr_addr == ADDR_ACCESS_KEY) begin
			if (sfr_wdata == KEY_FIRST) begin
				st_next.key_st = RSBS_KEY_ARMED;
			end else if (sfr_wdata == KEY_SECOND && st_reg.key_st == RSBS_KEY_ARMED) begin
				st_next.key_st = RSBS_KEY_OPEN;
				st_next.key_cnt = KEY_WINDOW_CYCLES - 3'h1;
			end else begin
				st_next.key_st = RSBS_KEY_IDLE;
			end
		end

		soft_go = prot_hit && (sfr_addr == ADDR_CHIP_CONTROL) && sfr_wdata[CHP_TRIG_BIT];

		wdt_go = wdt_timeout && !(power_down && clock_divider_value != CLKDIV_UNDIVIDED);
		st_next.wd_lost = wdt_timeout && !wdt_go;
		pin_go = ext_if.held_low;
		any_go = soft_go || wdt_go || pin_go || bod_reset_event || hardfault_event;
		reload_boot = wdt_go || pin_go || bod_reset_event || hardfault_event;

		// software writes come first so that a same-cycle event wins below
		if (wr && sfr_addr == ADDR_CHIP_CONTROL && key_open) begin
			st_next.prog_fail = sfr_wdata[CHP_PROG_FAIL_BIT];
			st_next.boot_sel = sfr_wdata[CHP_BOOT_BIT];
			st_next.prog_en = sfr_wdata[CHP_PROG_EN_BIT];
		end
		if (wr && sfr_addr == ADDR_AUX_CONTROL) begin
			st_next.soft_flag = sfr_wdata[AUX_SOFT_FLAG_BIT];
			st_next.pin_flag = sfr_wdata[AUX_PIN_FLAG_BIT];
			st_next.fault_flag = sfr_wdata[AUX_FAULT_FLAG_BIT];
			st_next.spare = sfr_wdata[AUX_SPARE_BIT];
			st_next.serial_swap = sfr_wdata[AUX_SERIAL_SWAP_BIT];
			st_next.ptr_sel = sfr_wdata[AUX_PTR_SEL_BIT];
		end
		if (wr && sfr_addr == ADDR_POWER_CTL) begin
			st_next.pwr_on_flag = sfr_wdata[PWR_ON_FLAG_BIT];
		end
		if (wr && sfr_addr == ADDR_WDOG_CONTROL && key_open) begin
			st_next.wd_run = sfr_wdata[WD_RUN_BIT];
			st_next.wd_expired = sfr_wdata[WD_EXPIRED_BIT];
			st_next.wd_idle_run = sfr_wdata[WD_IDLE_RUN_BIT];
			st_next.wd_flag = sfr_wdata[WD_FLAG_BIT];
			st_next.wd_ps = sfr_wdata[2:0];
			st_next.wd_clear = sfr_wdata[WD_CLEAR_BIT];
		end

		if (cfg_load) begin
			st_next.cfg = cfg_data;
		end

		unique case (st_reg.st)
			RSBS_RUN: begin
				st_next.core_rst = 1'b0;
			end
			RSBS_HOLD: begin
				st_next.core_rst = 1'b1;
				if (st_reg.hold_cnt != 4'h0) begin
					st_next.hold_cnt = st_reg.hold_cnt - 4'h1;
				end else if (ext_if.level) begin
					// pin released and minimum hold served
					st_next.st = RSBS_RUN;
					st_next.core_rst = 1'b0;
					st_next.soft_trig = 1'b0;
					st_next.dbg_quasi = 1'b1;
					st_next.lso_cnt = 10'h000;
				end
			end
		endcase

		if (any_go) begin
			st_next.st = RSBS_HOLD;
			st_next.core_rst = 1'b1;
			st_next.hold_cnt = RST_HOLD_CYCLES - 4'h1;
			st_next.cold = 1'b0;
			st_next.soft_trig = st_reg.soft_trig || soft_go;
			st_next.key_st = RSBS_KEY_IDLE;
			// warm reset returns the plain control bits to their reset values
			st_next.prog_fail = 1'b0;
			st_next.prog_en = 1'b0;
			st_next.spare = 1'b0;
			st_next.serial_swap = 1'b0;
			st_next.ptr_sel = 1'b0;
			st_next.wd_run = 1'b0;
			st_next.wd_expired = 1'b0;
			st_next.wd_idle_run = 1'b0;
			st_next.wd_ps = WD_PRESCALE_RESET;
			st_next.wd_clear = 1'b0;
		end
		if (reload_boot) begin
			st_next.boot_sel = !st_reg.cfg[CFG_BOOT_BIT];
		end
		if (wdt_go) begin
			st_next.wd_flag = 1'b1;
		end
		if (soft_go) begin
			st_next.soft_flag = 1'b1;
		end
		if (pin_go) begin
			st_next.pin_flag = 1'b1;
		end
		if (hardfault_event) begin
			st_next.fault_flag = 1'b1;
		end

		if (st_reg.dbg_quasi && st_reg.st == RSBS_RUN && lso_if.rise) begin
			if (st_reg.lso_cnt == DBG_QUASI_LSO_CLKS - 10'h001) begin
				st_next.dbg_quasi = 1'b0;
			end else begin
				st_next.lso_cnt = st_reg.lso_cnt + 10'h001;
			end
		end

		// read data answers one cycle after the strobe and then holds
		if (sfr_rd) begin
			unique case (sfr_addr)
				ADDR_POWER_CTL: begin
					st_next.rdata = {3'h0, st_reg.pwr_on_flag, 4'h0};
				end
				ADDR_CHIP_CONTROL: begin
					st_next.rdata = {1'b0, st_reg.prog_fail, 4'h0, st_reg.boot_sel, st_reg.prog_en};
				end
				ADDR_AUX_CONTROL: begin
					st_next.rdata = {st_reg.soft_flag, st_reg.pin_flag, st_reg.fault_flag, 1'b0,
						st_reg.spare, st_reg.serial_swap, 1'b0, st_reg.ptr_sel};
				end
				ADDR_WDOG_CONTROL: begin
					st_next.rdata = {st_reg.wd_run, 1'b0, st_reg.wd_expired, st_reg.wd_idle_run,
						st_reg.wd_flag, st_reg.wd_ps};
				end
				default: begin
					st_next.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.st <= RSBS_HOLD;
			st_reg.hold_cnt <= RST_HOLD_CYCLES - 4'h1;
			st_reg.core_rst <= 1'b1;
			st_reg.pwr_on_flag <= 1'b1;
			st_reg.cold <= 1'b1;
			st_reg.cfg <= CFG_RESET;
			st_reg.boot_sel <= !CFG_RESET[CFG_BOOT_BIT];
			st_reg.wd_ps <= WD_PRESCALE_RESET;
			st_reg.key_st <= RSBS_KEY_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sfr_rdata = st_reg.rdata;
	assign core_rst = st_reg.core_rst;
	assign cpu_stall = soft_go || st_reg.core_rst;
	assign boot_loader_sel = st_reg.boot_sel;
	assign fetch_addr = BOOT_VECTOR;
	assign stack_init = SP_RESET;
	assign port_latch_init = PORT_LATCH_RESET;
	assign port_input_only = st_reg.core_rst;
	assign periph_irq_disable = st_reg.core_rst;
	assign ram_retained = !st_reg.cold;
	assign debug_pin_quasi = st_reg.dbg_quasi;
	assign wdt_clear = st_reg.wd_clear;
	assign wdt_run = st_reg.wd_run;
	assign wdt_prescale = st_reg.wd_ps;
	assign wdt_reset_lost = st_reg.wd_lost;
endmodule : rsbs_reset_boot

// file: rsbs_reset_boot_asserts.sv
// rsbs_reset_boot_asserts: port-level timing checks for the reset sequencer.
// assumes it is bound into rsbs_reset_boot and sees only that module's ports.
`timescale 1ns/100ps
module rsbs_reset_boot_asserts (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic wdt_timeout,
	input wire logic power_down,
	input wire logic [7:0] clock_divider_value,
	input wire logic core_rst,
	input wire logic cpu_stall,
	input wire logic [15:0] fetch_addr,
	input wire logic [7:0] stack_init,
	input wire logic [7:0] port_latch_init,
	input wire logic port_input_only,
	input wire logic periph_irq_disable,
	input wire logic wdt_clear,
	input wire logic wdt_reset_lost
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic wd_ok;
	// divided clock in power-down swallows the time-out
	assign wd_ok = wdt_timeout && !(power_down && clock_divider_value != 8'h00);
	sequence unlock_s;
		sfr_wr && sfr_addr == 8'hc7 && sfr_wdata == 8'haa && !core_rst ##1
		sfr_wr && sfr_addr == 8'hc7 && sfr_wdata == 8'h55 && !core_rst;
	endsequence
	chk_wd_resets: assert property (wd_ok |=> core_rst)
		else $error("watchdog time-out did not reset the core");
	chk_wd_lost: assert property (wdt_timeout && !wd_ok |=> wdt_reset_lost)
		else $error("suppressed time-out not reported");
	chk_vec_hold: assert property (core_rst |-> fetch_addr == 16'h0000 && stack_init == 8'h07)
		else $error("reset vector or stack value wrong");
	chk_port_safe: assert property (port_input_only == core_rst && periph_irq_disable == core_rst
		&& port_latch_init == 8'hff)
		else $error("port or peripheral state wrong around reset");
	chk_last_instr: assert property (core_rst |-> cpu_stall)
		else $error("core not stalled during reset");
	chk_hold_two: assert property ($rose(core_rst) |-> core_rst ##1 core_rst)
		else $error("core reset shorter than two cycles");
	chk_soft_trig: assert property (unlock_s ##1 sfr_wr && sfr_addr == 8'h9f && sfr_wdata[7] && !core_rst
		|-> cpu_stall ##1 core_rst)
		else $error("unlocked trigger write did not reset");
	chk_wd_clear: assert property (unlock_s ##1 sfr_wr && sfr_addr == 8'haa && sfr_wdata[6] && !core_rst
		|=> wdt_clear)
		else $error("watchdog clear pulse missing");
	cover property (unlock_s ##1 sfr_wr && sfr_addr == 8'h9f);
	cover property (wdt_reset_lost);
	cover property ($rose(core_rst));
endmodule : rsbs_reset_boot_asserts

bind rsbs_reset_boot rsbs_reset_boot_asserts u_chk (.sys_clk, .srst, .sfr_addr, .sfr_wr, .sfr_wdata,
	.wdt_timeout, .power_down, .clock_divider_value, .core_rst, .cpu_stall, .fetch_addr, .stack_init,
	.port_latch_init, .port_input_only, .periph_irq_disable, .wdt_clear, .wdt_reset_lost);

// file: rsbs_reset_boot_test.sv
// rsbs_reset_boot_test: self-checking bench, every reset source against a flag model.
// assumes the package, the design and the bound checker are compiled first.
`timescale 1ns/100ps
module rsbs_reset_boot_test;
	logic sys_clk = 1'b0, srst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, ext_rst_n = 1'b1;
	logic wdt_timeout = 1'b0, bod_reset_event = 1'b0, hardfault_event = 1'b0;
	logic power_down = 1'b0, cfg_load = 1'b0, prv = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, clock_divider_value = 8'h00, cfg_data = 8'hff;
	logic [2:0] lso_div = 3'h0;
	logic [7:0] sfr_rdata, got, v;
	logic core_rst, cpu_stall, boot_loader_sel, ram_ok, dbg_q, wd_run_o;
	logic [2:0] wd_ps_o;
	logic po_f, sw_f, pin_f, hf_f, wd_f, bsel, cfg7;
	int err_total = 0, cmp_count = 0, rst_cnt = 0, n_q = 0;
	logic [7:0] addrs [5] = '{8'h87, 8'h9f, 8'ha2, 8'haa, 8'h55};

	rsbs_reset_boot DUT (.sys_clk, .srst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata, .ext_rst_n,
		.low_speed_osc(lso_div[2]), .wdt_timeout, .bod_reset_event, .hardfault_event, .power_down,
		.clock_divider_value, .cfg_load, .cfg_data, .core_rst, .cpu_stall, .boot_loader_sel,
		.fetch_addr(), .stack_init(), .port_latch_init(), .port_input_only(), .periph_irq_disable(),
		.ram_retained(ram_ok), .debug_pin_quasi(dbg_q), .wdt_clear(), .wdt_run(wd_run_o), .wdt_prescale(wd_ps_o),
		.wdt_reset_lost());

	initial forever #25 sys_clk = ~sys_clk;
	// counts core reset entries so a missed or doubled reset shows
	always @(posedge sys_clk) begin
		lso_div <= lso_div + 3'h1;
		prv <= core_rst;
		if (core_rst && !prv)
			rst_cnt <= rst_cnt + 1;
	end

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] exp, input logic [7:0] act);
		cmp_count++;
		if (act !== exp) begin
			err_total++;
			$display("wrong value at %0t: expected %h got %h", $time, exp, act);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_rd <= 1'b0;
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge sys_clk);
	endtask : wr

	task automatic idle(input int n);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask : idle

	// key bytes, then the guarded write
	task automatic pwr(input logic [7:0] a, input logic [7:0] d);
		wr(8'hc7, 8'haa);
		wr(8'hc7, 8'h55);
		wr(a, d);
		idle(1);
	endtask : pwr

	task automatic rd(input logic [7:0] a);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
		@(posedge sys_clk);
		got = sfr_rdata;
	endtask : rd

	function automatic logic [7:0] expect_reg(input logic [7:0] a);
		case (a)
			8'h87: return {3'h0, po_f, 4'h0};
			8'h9f: return {6'h0, bsel, 1'b0};
			8'ha2: return {sw_f, pin_f, hf_f, 5'h0};
			8'haa: return {4'h0, wd_f, 3'h0};
			default: return 8'h00;
		endcase
	endfunction : expect_reg

	task automatic check_all();
		foreach (addrs[i]) begin
			rd(addrs[i]);
			chk(expect_reg(addrs[i]), got);
		end
		chk({7'h0, bsel}, {7'h0, boot_loader_sel});
	endtask : check_all

	task automatic settle();
		int n;
		n = 0;
		repeat (4) @(posedge sys_clk);
		while (core_rst !== 1'b0 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 200) begin
			err_total++;
			conclude();
		end
		idle(2);
	endtask : settle

	// k: 0 watchdog, 1 software, 2 pin, 3 fault, 4 brown-out
	task automatic fire(input int k);
		int base;
		base = rst_cnt;
		case (k)
			0: wdt_timeout <= 1'b1;
			1: begin
				rd(8'h9f);
				pwr(8'h9f, got | 8'h80);
			end
			2: ext_rst_n <= 1'b0;
			3: hardfault_event <= 1'b1;
			default: bod_reset_event <= 1'b1;
		endcase
		@(posedge sys_clk);
		wdt_timeout <= 1'b0;
		hardfault_event <= 1'b0;
		bod_reset_event <= 1'b0;
		if (k == 2)
			repeat (34) @(posedge sys_clk);
		ext_rst_n <= 1'b1;
		settle();
		chk(8'h01, 8'(rst_cnt - base));
		case (k)
			0: wd_f = 1'b1;
			1: sw_f = 1'b1;
			2: pin_f = 1'b1;
			3: hf_f = 1'b1;
			default: ;
		endcase
		if (k != 1)
			bsel = !cfg7;
		check_all();
		chk(8'h01, {7'h0, ram_ok});
	endtask : fire

	initial begin
		void'($urandom(33));
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		{po_f, sw_f, pin_f, hf_f, wd_f, bsel, cfg7} = 7'b1000001;
		settle();
		check_all();
		chk(8'h01, {7'h0, dbg_q});
		chk(8'h00, {7'h0, ram_ok});
		v = 8'(rst_cnt);
		wr(8'h9f, 8'h80);
		idle(8);
		chk(v, 8'(rst_cnt));
		power_down <= 1'b1;
		clock_divider_value <= 8'($urandom_range(255, 1));
		@(posedge sys_clk);
		wdt_timeout <= 1'b1;
		@(posedge sys_clk);
		wdt_timeout <= 1'b0;
		idle(8);
		power_down <= 1'b0;
		chk(v, 8'(rst_cnt));
		for (int r = 0; r < 10; r++) begin
			v = 8'($urandom);
			cfg_data <= v;
			cfg_load <= 1'b1;
			cfg7 = v[7];
			@(posedge sys_clk);
			cfg_load <= 1'b0;
			wr(8'h87, v & 8'h10);
			po_f = v[4];
			wr(8'ha2, v & 8'he0);
			{sw_f, pin_f, hf_f} = v[7:5];
			pwr(8'haa, (v & 8'h8f) | 8'h40);
			wd_f = v[3];
			chk({4'h0, v[7], v[2:0]}, {4'h0, wd_run_o, wd_ps_o});
			fire(r % 5);
		end
		// a second cold reset in mid-run clears every warm flag again
		srst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		{po_f, sw_f, pin_f, hf_f, wd_f, bsel, cfg7} = 7'b1000001;
		settle();
		chk(8'h01, {7'h0, dbg_q});
		while (dbg_q !== 1'b0 && n_q < 6000) begin
			@(posedge sys_clk);
			n_q++;
		end
		// 600 slow rises at eight system clocks each, a few already spent in settle
		chk(8'h01, {7'h0, n_q > 4700 && n_q < 4900});
		check_all();
		chk(8'h00, {7'h0, ram_ok});
		conclude();
	end
endmodule : rsbs_reset_boot_test
